// File: src/sma_pkg.sv
/*
 * sma_pkg: constants and types shared by the presence-detect attribute
 * byte table and its register slave.
 * assumes: included first; no other package needed.
 */
package sma_pkg;

    // table byte positions; byte address on the bus is four times these
    localparam logic [7:0] SMA_IDX_PRI_WIDTH   = 8'h0d;
    localparam logic [7:0] SMA_IDX_EC_WIDTH    = 8'h0e;
    localparam logic [7:0] SMA_IDX_RAND_COL    = 8'h0f;
    localparam logic [7:0] SMA_IDX_BURST       = 8'h10;
    localparam logic [7:0] SMA_IDX_BANKS       = 8'h11;
    localparam logic [7:0] SMA_IDX_CAS_LAT     = 8'h12;
    localparam logic [7:0] SMA_IDX_CS_LAT      = 8'h13;
    localparam logic [7:0] SMA_IDX_WE_LAT      = 8'h14;
    localparam logic [7:0] SMA_IDX_ATTR        = 8'h15;
    localparam int         SMA_TBL_BYTES       = 9;

    // own control and status words
    localparam logic [7:0] SMA_IDX_CTRL        = 8'h20;
    localparam logic [7:0] SMA_IDX_PROBE_IDX   = 8'h21;
    localparam logic [7:0] SMA_IDX_PROBE_DATA  = 8'h22;
    localparam logic [7:0] SMA_IDX_STATUS      = 8'h23;

    // field positions
    localparam int         SMA_BIT_DOUBLE      = 7;
    localparam int         SMA_BIT_AUTOINC     = 0;
    localparam logic [7:0] SMA_WIDTH_MASK      = 8'h7f;
    localparam logic [7:0] SMA_BURST_MASK      = 8'h8f;
    localparam logic [7:0] SMA_LAT_MASK        = 8'h7f;
    localparam logic [7:0] SMA_ATTR_MASK       = 8'h7f;

    // status bits: a count field that reads zero
    localparam int         SMA_ST_PRI_UNDEF    = 0;
    localparam int         SMA_ST_EC_UNDEF     = 1;
    localparam int         SMA_ST_RAND_UNDEF   = 2;
    localparam int         SMA_ST_BANKS_RESVD  = 3;
    localparam int         SMA_ST_BITS         = 4;

    // reset values
    localparam logic       SMA_RST_AUTOINC     = 1'b0;
    localparam logic [7:0] SMA_RST_PROBE_IDX   = 8'h0d;
    localparam logic [31:0] SMA_RST_RDATA      = 32'h0000_0000;

    typedef enum logic [1:0] {
        SMA_PH_IDLE  = 2'b00,
        SMA_PH_WRITE = 2'b01,
        SMA_PH_READ  = 2'b10,
        SMA_PH_RDONE = 2'b11
    } sma_phase_t;

    typedef struct packed {
        sma_phase_t  phase;
        logic [7:0]  widx;
        logic        autoinc;
        logic [7:0]  probe_idx;
        logic [31:0] rdata;
    } sma_state_t;

endpackage : sma_pkg

// File: src/sma_table_if.sv
/*
 * sma_table_if: carries the finished attribute bytes and their
 * undefined-count flags from the table builder to the bus slave.
 * assumes: both ends in one clock domain; contents are static.
 */
`timescale 1ns/1ps
interface sma_table_if;
    import sma_pkg::*;
    logic [SMA_TBL_BYTES-1:0][7:0] bytes;
    logic [SMA_ST_BITS-1:0]        undef;
    modport builder (output bytes, output undef);
    modport reader  (input bytes, input undef);
endinterface : sma_table_if

// File: src/sma_attr_table.sv
/*
 * sma_attr_table: forms the nine attribute bytes from the module build
 * parameters and flags count fields that would read zero.
 * assumes: parameters are fixed per module build; output is static.
 */
`timescale 1ns/1ps
module sma_attr_table
    import sma_pkg::*;
#(
    parameter logic [7:0] PRI_WIDTH      = 8'h08,
    parameter logic       HAS_BANK2      = 1'b0,
    parameter logic       PRI_BANK2_DBL  = 1'b0,
    parameter logic       EC_SEPARATE    = 1'b1,
    parameter logic [7:0] EC_WIDTH       = 8'h08,
    parameter logic       EC_BANK2_DBL   = 1'b0,
    parameter logic [7:0] RAND_COL_CLKS  = 8'h01,
    parameter logic [7:0] BURST_LENGTHS  = 8'h8f,
    parameter logic [7:0] DEV_BANKS      = 8'h04,
    parameter logic [7:0] CAS_LATS       = 8'h06,
    parameter logic [7:0] CS_LATS        = 8'h01,
    parameter logic [7:0] WE_LATS        = 8'h01,
    parameter logic [7:0] MOD_ATTRS      = 8'h00
) (
    sma_table_if.builder tbl
);
    logic [7:0] pri_b;
    logic [7:0] ec_b;

    // double-width flag only means something with a second bank
    assign pri_b = {HAS_BANK2 & PRI_BANK2_DBL,
                    PRI_WIDTH[6:0]};
    assign ec_b  = EC_SEPARATE ? {HAS_BANK2 & EC_BANK2_DBL,
                                  EC_WIDTH[6:0]} : 8'h00;

    assign tbl.bytes[0] = pri_b;
    assign tbl.bytes[1] = ec_b;
    assign tbl.bytes[2] = RAND_COL_CLKS;
    assign tbl.bytes[3] = BURST_LENGTHS & SMA_BURST_MASK;
    assign tbl.bytes[4] = DEV_BANKS;
    assign tbl.bytes[5] = CAS_LATS & SMA_LAT_MASK;
    assign tbl.bytes[6] = CS_LATS & SMA_LAT_MASK;
    assign tbl.bytes[7] = WE_LATS & SMA_LAT_MASK;
    assign tbl.bytes[8] = MOD_ATTRS & SMA_ATTR_MASK;

    assign tbl.undef[SMA_ST_PRI_UNDEF]   = (pri_b[6:0] == 7'h00);
    assign tbl.undef[SMA_ST_EC_UNDEF]    = EC_SEPARATE &&
                                           (ec_b[6:0] == 7'h00);
    assign tbl.undef[SMA_ST_RAND_UNDEF]  = (RAND_COL_CLKS == 8'h00);
    assign tbl.undef[SMA_ST_BANKS_RESVD] = (DEV_BANKS == 8'h00);

endmodule : sma_attr_table

// File: src/sma_attr_top.sv
/*
 * sma_attr_top: presence-detect attribute bytes 13 to 21 of a memory
 * module, read over an AHB-Lite slave, with an indexed probe port.
 * assumes: single AHB-Lite master, word transfers, one clock domain.
 */
// Overview of operation
// - byte 13 low seven bits give the data component width, zero undefined.
// - byte 13 bit 7 is set only when bank 2 data parts are twice as wide.
// - byte 14 holds a width only when error checking has its own parts.
// - byte 14 low seven bits give the check component width, zero undefined.
// - byte 14 bit 7 is set only when bank 2 check parts are twice as wide.
// - byte 15 gives minimum clocks between random column addresses.
// - byte 16 is a burst bitmap for 1, 2, 4, 8 and page, bits 6 to 4 zero.
// - byte 17 gives internal banks per component, zero reserved.
// - byte 18 bits 0 to 6 mark column strobe latencies 1 to 7.
// - byte 19 bits 0 to 6 mark chip select latencies 0 to 6.
// - byte 20 bits 0 to 6 mark write enable latencies 0 to 6.
// - byte 21 flags module buffering and clocking, bit 7 zero.
`timescale 1ns/1ps
module sma_attr_top
    import sma_pkg::*;
#(
    parameter logic [7:0] PRI_WIDTH      = 8'h08,
    parameter logic       HAS_BANK2      = 1'b0,
    parameter logic       PRI_BANK2_DBL  = 1'b0,
    parameter logic       EC_SEPARATE    = 1'b1,
    parameter logic [7:0] EC_WIDTH       = 8'h08,
    parameter logic       EC_BANK2_DBL   = 1'b0,
    parameter logic [7:0] RAND_COL_CLKS  = 8'h01,
    parameter logic [7:0] BURST_LENGTHS  = 8'h8f,
    parameter logic [7:0] DEV_BANKS      = 8'h04,
    parameter logic [7:0] CAS_LATS       = 8'h06,
    parameter logic [7:0] CS_LATS        = 8'h01,
    parameter logic [7:0] WE_LATS        = 8'h01,
    parameter logic [7:0] MOD_ATTRS      = 8'h00
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_clk_en,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp
);

    sma_table_if tbl_if ();

    sma_attr_table #(
        .PRI_WIDTH     (PRI_WIDTH),
        .HAS_BANK2     (HAS_BANK2),
        .PRI_BANK2_DBL (PRI_BANK2_DBL),
        .EC_SEPARATE   (EC_SEPARATE),
        .EC_WIDTH      (EC_WIDTH),
        .EC_BANK2_DBL  (EC_BANK2_DBL),
        .RAND_COL_CLKS (RAND_COL_CLKS),
        .BURST_LENGTHS (BURST_LENGTHS),
        .DEV_BANKS     (DEV_BANKS),
        .CAS_LATS      (CAS_LATS),
        .CS_LATS       (CS_LATS),
        .WE_LATS       (WE_LATS),
        .MOD_ATTRS     (MOD_ATTRS)
    ) u_table (
        .tbl (tbl_if.builder)
    );

    sma_state_t state_q;
    sma_state_t state_d;

    logic       addr_take;
    logic       in_table;
    logic [7:0] addr_widx;

    // byte of the table at a given position, zero outside 13..21
    function automatic logic [7:0] table_byte(
        input logic [7:0]                    idx,
        input logic [SMA_TBL_BYTES-1:0][7:0] bytes
    );
        logic [7:0] off;
        logic [7:0] val;
        off = idx - SMA_IDX_PRI_WIDTH;
        val = 8'h00;
        if (idx >= SMA_IDX_PRI_WIDTH && idx <= SMA_IDX_ATTR) begin
            val = bytes[off[3:0]];
        end
        return val;
    endfunction : table_byte

    // full word decode for a read; unmapped words read zero
    function automatic logic [31:0] read_word(
        input logic [7:0]                    idx,
        input sma_state_t                    st,
        input logic [SMA_TBL_BYTES-1:0][7:0] bytes,
        input logic [SMA_ST_BITS-1:0]        undef
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            SMA_IDX_CTRL: begin
                w[SMA_BIT_AUTOINC] = st.autoinc;
            end
            SMA_IDX_PROBE_IDX: begin
                w[7:0] = st.probe_idx;
            end
            SMA_IDX_PROBE_DATA: begin
                w[7:0] = table_byte(st.probe_idx, bytes);
            end
            SMA_IDX_STATUS: begin
                w[SMA_ST_BITS-1:0] = undef;
            end
            default: begin
                w[7:0] = table_byte(idx, bytes);
            end
        endcase
        return w;
    endfunction : read_word

    assign addr_widx = (i_haddr[31:10] == 22'h00_0000) ?
                       i_haddr[9:2] : 8'hff;
    assign in_table  = (state_q.widx >= SMA_IDX_PRI_WIDTH) &&
                       (state_q.widx <= SMA_IDX_ATTR);
    // a read holds one wait state so the answer always comes from flops
    assign o_hreadyout = (state_q.phase != SMA_PH_READ);
    assign o_hresp     = 1'b0;
    assign o_hrdata    = state_q.rdata;
    assign addr_take   = i_hsel && i_htrans[1] && i_hready;

    always_comb begin
        state_d = state_q;
        case (state_q.phase)
            SMA_PH_WRITE: begin
                // the table is read only; writes there are dropped
                if (!in_table) begin
                    case (state_q.widx)
                        SMA_IDX_CTRL: begin
                            state_d.autoinc = i_hwdata[SMA_BIT_AUTOINC];
                        end
                        SMA_IDX_PROBE_IDX: begin
                            state_d.probe_idx = i_hwdata[7:0];
                        end
                        default: begin
                            state_d.autoinc = state_q.autoinc;
                        end
                    endcase
                end
            end
            SMA_PH_READ: begin
                state_d.rdata = read_word(state_q.widx, state_q,
                                          tbl_if.bytes,
                                          tbl_if.undef);
                // probe walks the table like a sequential serial read
                if (state_q.widx == SMA_IDX_PROBE_DATA &&
                    state_q.autoinc) begin
                    state_d.probe_idx = state_q.probe_idx + 8'h01;
                end
            end
            default: begin
                state_d.rdata = state_q.rdata;
            end
        endcase
        if (state_q.phase != SMA_PH_READ) begin
            state_d.phase = SMA_PH_IDLE;
            if (addr_take) begin
                state_d.widx  = addr_widx;
                state_d.phase = i_hwrite ? SMA_PH_WRITE : SMA_PH_READ;
            end
        end else begin
            state_d.phase = SMA_PH_RDONE;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q.phase     <= SMA_PH_IDLE;
            state_q.widx      <= 8'h00;
            state_q.autoinc   <= SMA_RST_AUTOINC;
            state_q.probe_idx <= SMA_RST_PROBE_IDX;
            state_q.rdata     <= SMA_RST_RDATA;
        end else if (i_clk_en) begin
            state_q <= state_d;
        end
    end

endmodule : sma_attr_top

// File: testbench/sma_attr_assertions.sv
/* sma_attr_assertions: bus timing and byte field checks on the top ports.
   assumes: bound to sma_attr_top; one clock, async active-high reset. */
`timescale 1ns/1ps
module sma_attr_assertions
    import sma_pkg::*;
#(
    parameter logic [7:0] PRI_WIDTH   = 8'h08,
    parameter logic       EC_SEPARATE = 1'b1,
    parameter logic [7:0] EC_WIDTH    = 8'h08
) (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_clk_en,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic go;
    assign go = i_clk_en && i_hsel && i_htrans[1] && i_hready;
    sequence rd_at(logic [31:0] a);
        go && !i_hwrite && i_haddr == a;
    endsequence
    a_pri_width: assert property (rd_at(32'h34) |-> ##2
        o_hrdata[6:0] == PRI_WIDTH[6:0]) else $error("byte 13 width");
    a_ec_width: assert property (rd_at(32'h38) |-> ##2
        o_hrdata[6:0] == (EC_SEPARATE ? EC_WIDTH[6:0] : 7'h00))
        else $error("byte 14 width");
    a_burst_gap: assert property (rd_at(32'h40) |-> ##2
        o_hrdata[6:4] == 3'h0) else $error("burst bits 6:4 set");
    a_lat_top: assert property (go && !i_hwrite &&
        i_haddr inside {32'h48, 32'h4c, 32'h50} |-> ##2 !o_hrdata[7])
        else $error("latency bit 7 set");
    a_attr_top: assert property (rd_at(32'h54) |-> ##2
        !o_hrdata[7]) else $error("attribute bit 7 set");
    a_read_wait: assert property (go && !i_hwrite |=>
        !o_hreadyout ##1 o_hreadyout) else $error("read wait state");
    a_write_nowait: assert property (go && i_hwrite |=> o_hreadyout)
        else $error("write stalled");
    a_data_stands: assert property ($changed(o_hrdata) |->
        !$past(o_hreadyout)) else $error("read data moved");
    a_upper_zero: assert property (o_hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_resp_okay: assert property (o_hresp == 1'b0) else $error("not okay");
    c_read_b13: cover property (rd_at(32'h34));
    c_write: cover property (go && i_hwrite);
    c_probe: cover property (rd_at(32'h88));
endmodule : sma_attr_assertions

bind sma_attr_top sma_attr_assertions #(
    .PRI_WIDTH(PRI_WIDTH), .EC_SEPARATE(EC_SEPARATE), .EC_WIDTH(EC_WIDTH)
) u_chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp)
);

// File: testbench/sma_host_model.sv
/* sma_host_model: AHB-Lite master standing for the memory controller that
   reads the table, with its own decoding of the count fields.
   assumes: one slave whose hreadyout is fed back as hready. */
`timescale 1ns/1ps
module sma_host_model (
    input  wire logic        i_clock,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hrdata,
    output logic             o_hsel,
    output logic [31:0]      o_haddr,
    output logic [1:0]       o_htrans,
    output logic             o_hwrite,
    output logic [2:0]       o_hsize,
    output logic [31:0]      o_hwdata
);
    initial begin
        o_hsel = 1'b1;
        o_haddr = 32'h0;
        o_htrans = 2'b00;
        o_hwrite = 1'b0;
        o_hsize = 3'b010;
        o_hwdata = 32'h0;
    end
    task automatic wait_rdy();
        do @(posedge i_clock); while (i_hready !== 1'b1);
    endtask : wait_rdy
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge i_clock);
        o_htrans <= 2'b10;
        o_haddr  <= a;
        o_hwrite <= 1'b0;
        wait_rdy();
        o_htrans <= 2'b00;
        wait_rdy();
        d = i_hrdata;
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clock);
        o_htrans <= 2'b10;
        o_haddr  <= a;
        o_hwrite <= 1'b1;
        wait_rdy();
        o_htrans <= 2'b00;
        o_hwdata <= d;
        wait_rdy();
        o_hwrite <= 1'b0;
        o_hwdata <= ~d; // stale data never lingers on the bus
    endtask : wr
    // zero counts are invalid, never used as sizes; byte 13 counts data
    // parts only, check parts come from byte 14
    function automatic logic [3:0] undef_flags(input logic [7:0] b13,
        input logic [7:0] b14, input logic [7:0] b15, input logic [7:0] b17,
        input logic ec_sep);
        undef_flags = {b17 == 8'h00, b15 == 8'h00,
            ec_sep && b14[6:0] == 7'h00, b13[6:0] == 7'h00};
    endfunction : undef_flags
    // one flag covers address, strobes, write enable, clock enable, select
    function automatic logic cmd_pins_buffered(input logic [7:0] b21);
        cmd_pins_buffered = b21[0];
    endfunction : cmd_pins_buffered
endmodule : sma_host_model

// File: testbench/tb_top.sv
/* tb_top: reads the attribute table over AHB-Lite through the host model
   and compares each word with values worked out from the build values.
   assumes: 200 MHz clock, reset held 8 cycles, clock enable dropped once
   to show that a frozen block ignores the bus. */
`timescale 1ns/1ps
module tb_top;
    import sma_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        flag_seen;
    logic [3:0]  undef_exp;
    logic [31:0] probe_exp;
    logic [31:0] seen_tbl [9];
    logic        hsel, hwrite, hready, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    int          err_total = 0;
    int          check_count = 0;
    // odd build values: doubled bank 2, zero check width and zero banks
    localparam logic [7:0] B_PRI_WIDTH = 8'h10;
    localparam logic       B_HAS_BANK2 = 1'b1;
    localparam logic       B_PRI_DBL   = 1'b1;
    localparam logic       B_EC_SEP    = 1'b1;
    localparam logic [7:0] B_EC_WIDTH  = 8'h00;
    localparam logic       B_EC_DBL    = 1'b1;
    localparam logic [7:0] B_RAND_COL  = 8'hff;
    localparam logic [7:0] B_BURSTS    = 8'hff;
    localparam logic [7:0] B_BANKS     = 8'h00;
    localparam logic [7:0] B_CAS       = 8'hff;
    localparam logic [7:0] B_CS        = 8'h81;
    localparam logic [7:0] B_WE        = 8'hc0;
    localparam logic [7:0] B_ATTRS     = 8'hff;
    // masked bits and the bank 2 gating worked out by hand
    logic [7:0]  exp_tbl [9] = '{8'h90, 8'h80, 8'hff, 8'h8f, 8'h00,
                                 8'h7f, 8'h01, 8'h40, 8'h7f};
    always #2.5 clock = ~clock;
    sma_attr_top #(.PRI_WIDTH(B_PRI_WIDTH), .HAS_BANK2(B_HAS_BANK2),
        .PRI_BANK2_DBL(B_PRI_DBL), .EC_SEPARATE(B_EC_SEP),
        .EC_WIDTH(B_EC_WIDTH), .EC_BANK2_DBL(B_EC_DBL),
        .RAND_COL_CLKS(B_RAND_COL), .BURST_LENGTHS(B_BURSTS),
        .DEV_BANKS(B_BANKS), .CAS_LATS(B_CAS), .CS_LATS(B_CS),
        .WE_LATS(B_WE), .MOD_ATTRS(B_ATTRS)) DUT (
        .i_clock(clock), .i_rst(rst), .i_clk_en(clk_en), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));
    sma_host_model HOST (.i_clock(clock), .i_hready(hready),
        .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #(5 * 4000);
        err_total++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        HOST.rd(32'h80, rdat);
        check(rdat, 32'h0000_0000);
        HOST.rd(32'h84, rdat);
        check(rdat, 32'h0000_000d);
        HOST.rd(32'h3fc, rdat);
        check(rdat, 32'h0000_0000);
        for (int i = 0; i < SMA_TBL_BYTES; i++) begin
            HOST.rd(32'h34 + 4 * i, seen_tbl[i]);
        end
        check(seen_tbl[0], {24'h0, exp_tbl[0]});
        check(seen_tbl[1], {24'h0, exp_tbl[1]});
        check(seen_tbl[2], {24'h0, exp_tbl[2]});
        check(seen_tbl[3], {24'h0, exp_tbl[3]});
        check(seen_tbl[4], {24'h0, exp_tbl[4]});
        check(seen_tbl[5], {24'h0, exp_tbl[5]});
        check(seen_tbl[6], {24'h0, exp_tbl[6]});
        check(seen_tbl[7], {24'h0, exp_tbl[7]});
        check(seen_tbl[8], {24'h0, exp_tbl[8]});
        flag_seen = HOST.cmd_pins_buffered(seen_tbl[8][7:0]);
        check({31'h0, flag_seen}, 32'h0000_0001);
        HOST.wr(32'h34, 32'h0000_00ff);
        HOST.rd(32'h34, rdat);
        check(rdat, 32'h0000_0090);
        HOST.rd(32'h8c, rdat);
        undef_exp = HOST.undef_flags(exp_tbl[0], exp_tbl[1], exp_tbl[2],
                                     exp_tbl[4], B_EC_SEP);
        check(rdat, {28'h0, undef_exp});
        HOST.wr(32'h80, 32'h0000_0001);
        HOST.wr(32'h84, 32'h0000_000c);
        for (int i = 12; i < 23; i++) begin
            HOST.rd(32'h88, rdat);
            probe_exp = 32'h0000_0000;
            if (i > 12 && i < 22) begin
                probe_exp = {24'h0, exp_tbl[i - 13]};
            end
            check(rdat, probe_exp);
        end
        HOST.rd(32'h84, rdat);
        check(rdat, 32'h0000_0017);
        HOST.wr(32'h84, 32'h0000_00ff);
        HOST.rd(32'h88, rdat);
        check(rdat, 32'h0000_0000);
        HOST.rd(32'h84, rdat);
        check(rdat, 32'h0000_0000);
        // a write while the block is frozen must not land
        clk_en <= 1'b0;
        HOST.wr(32'h84, 32'h0000_0033);
        clk_en <= 1'b1;
        HOST.rd(32'h84, rdat);
        check(rdat, 32'h0000_0000);
        // reset in mid-run brings the control words back
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        check({31'h0, hready}, 32'h0000_0001);
        check(hrdata, 32'h0000_0000);
        rst <= 1'b0;
        HOST.rd(32'h80, rdat);
        check(rdat, 32'h0000_0000);
        HOST.rd(32'h84, rdat);
        check(rdat, 32'h0000_000d);
        check({31'h0, hresp}, 32'h0000_0000);
        test_done();
    end
endmodule : tb_top
